/* verilog/fsrb_top.sv */
// Status register bank of a serial NOR flash, reached over its serial pins.
// Assumes sclk, cs_n, si and wp_n arrive asynchronously and clk_i is much
// faster than sclk.
// Summary of operation
// - Busy bit set during program, erase or status write, else zero.
// - Write enable latch shown; writes, programs, erases rejected while it is zero.
// - Five protect bits choose protected area; written by status write.
// - Protect bits writable only outside hardware-protected mode.
// - Chip erase runs only when nothing is protected.
// - Method bits 00: status writable after write enable.
// - Method 01 with write-protect low: status locked.
// - Method 01 with write-protect high: writable after write enable.
// - Method high set blocks writes until power, soft or hardware reset clears it.
// - Prefix pair before the write makes the status lock survive soft reset; hardware reset clears it.
// - Current address width bit reads 0 for 3-byte, 1 for 4-byte.
// - Quad enable always reads one, writes ignored.
// - Suspend sets erase or program suspend bit by job kind.
// - Resume, soft reset and power cycle clear both suspend bits.
// - Three security lock bits set individually; only hardware reset clears them.
// - Fast, dual and quad output reads always use 8 dummy clocks.
// - Dual I/O reads: settings 00,10 give 4; 01,11 give 8.
// - Quad I/O reads: 00,01 give 6; 10 gives 8; 11 gives 10.
// - Complement bit alters how protect bits decode the area.
// - Power-up address bit loaded into current width at reset only.
`default_nettype none

module fsrb_top
  import fsrb_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  // Settings seen by the rest of the device
  output logic [3:0] fast_dummy_o,
  output logic [3:0] dual_io_dummy_o,
  output logic [3:0] quad_io_dummy_o,
  output logic current_addr_width_o,
  output logic [2:0] security_lock_o,
  output logic quad_io_enable_o
);

  // ------------------------------------------------------------------
  // Pin synchronisation and edges
  // ------------------------------------------------------------------
  logic [3:0] pins;
  logic sclk_s, cs_n_s, si_s, wp_n_s, sclk_prev_reg, cs_prev_reg;
  logic sclk_rise, sclk_fall, cs_rise;

  fsrb_pin_sync #(.W(4), .RST(RST_PINS)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .async_i({wp_n_i, si_i, cs_n_i, sclk_i}),
    .stable_o(pins)
  );

  assign {wp_n_s, si_s, cs_n_s, sclk_s} = pins;
  assign sclk_rise = sclk_s && !sclk_prev_reg && !cs_n_s;
  assign sclk_fall = !sclk_s && sclk_prev_reg && !cs_n_s;
  assign cs_rise = cs_n_s && !cs_prev_reg;

  // ------------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------------
  // Any part of the array protected, per protect bits and complement
  function automatic logic any_protected(input logic [4:0] bp, input logic cmp);
    logic none_c;
    none_c = (bp[3:2] == 2'b11) || (bp[3:0] == 4'b1011);
    any_protected = cmp ? !none_c : (bp[3:0] != 4'h0);
  endfunction : any_protected

  // Dual I/O latency from the two-bit setting
  function automatic logic [3:0] dio_dummy(input logic [1:0] sel);
    dio_dummy = sel[0] ? DUMMY_DIO_LONG : DUMMY_DIO_SHORT;
  endfunction : dio_dummy

  // Quad I/O latency from the two-bit setting
  function automatic logic [3:0] qio_dummy(input logic [1:0] sel);
    unique case (sel)
      2'b10: qio_dummy = DUMMY_QIO_MID;
      2'b11: qio_dummy = DUMMY_QIO_LONG;
      default: qio_dummy = DUMMY_QIO_SHORT;
    endcase
  endfunction : qio_dummy

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  fsrb_state_t state_reg, state_next;
  logic [7:0] op_reg, op_next, in_reg, in_next, out_reg, out_next;
  logic [7:0] wb1_reg, wb1_next, wb2_reg, wb2_next, wb3_reg, wb3_next;
  logic [2:0] bit_reg, bit_next;
  logic [1:0] cnt_reg, cnt_next, job_reg, job_next, pfx_reg, pfx_next;
  logic [15:0] tmr_reg, tmr_next;
  logic so_reg, so_next, wel_reg, wel_next, mlo_reg, mlo_next, mhi_reg, mhi_next;
  logic cmp_reg, cmp_next, esus_reg, esus_next, psus_reg, psus_next;
  logic cur_reg, cur_next, pwr_reg, pwr_next, otp_reg, otp_next, rarm_reg, rarm_next;
  logic [4:0] bp_reg, bp_next;
  logic [2:0] lock_reg, lock_next;
  logic [1:0] lat_reg, lat_next;
  logic [3:0] fdum_reg, ddum_reg, qdum_reg;
  logic busy, status_ok, reading, start_job, soft_rst;
  logic [7:0] sb1, sb2, sb3, op_full, rd_byte;

  // Busy pauses while a suspend is pending
  assign busy = (job_reg != JOB_NONE) && !(esus_reg || psus_reg);
  // Status write permission by method bits and write-protect pin
  assign status_ok = wel_reg && !otp_reg && !mhi_reg &&
                     !(mlo_reg && !wp_n_s);

  // Live status bytes; reserved bits read zero
  assign sb1 = {mlo_reg, bp_reg, wel_reg, busy};
  assign sb2 = {esus_reg, cmp_reg, lock_reg, psus_reg, 1'b1, mhi_reg};
  assign sb3 = {3'h0, pwr_reg, cur_reg, 1'b0, lat_reg};

  assign op_full = (state_reg == FS_OPCODE) ? {in_reg[6:0], si_s} : op_reg;
  assign reading = (op_reg == OP_READ_SB1) || (op_reg == OP_READ_SB2) ||
                   (op_reg == OP_READ_SB3);
  always_comb begin
    unique case (op_full)
      OP_READ_SB2: rd_byte = sb2;
      OP_READ_SB3: rd_byte = sb3;
      default: rd_byte = sb1;
    endcase
  end

  // ------------------------------------------------------------------
  // Next-state logic: framing, shifting and command execution
  // ------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    in_next = in_reg;
    out_next = out_reg;
    bit_next = bit_reg;
    cnt_next = cnt_reg;
    wb1_next = wb1_reg;
    wb2_next = wb2_reg;
    wb3_next = wb3_reg;
    so_next = so_reg;
    job_next = job_reg;
    tmr_next = tmr_reg;
    wel_next = wel_reg;
    bp_next = bp_reg;
    mlo_next = mlo_reg;
    mhi_next = mhi_reg;
    cmp_next = cmp_reg;
    lock_next = lock_reg;
    lat_next = lat_reg;
    pwr_next = pwr_reg;
    cur_next = cur_reg;
    esus_next = esus_reg;
    psus_next = psus_reg;
    otp_next = otp_reg;
    pfx_next = pfx_reg;
    rarm_next = rarm_reg;
    start_job = 1'b0;
    soft_rst = 1'b0;

    // Background job countdown, frozen while suspended
    if (busy) begin
      if (tmr_reg <= 16'h0001) begin
        job_next = JOB_NONE;
        tmr_next = 16'h0000;
      end else begin
        tmr_next = tmr_reg - 16'h0001;
      end
    end

    // Frame entry and serial shifting
    if (state_reg == FS_IDLE && !cs_n_s) begin
      state_next = FS_OPCODE;
      bit_next = 3'h0;
      cnt_next = 2'h0;
    end
    if (sclk_rise) begin
      in_next = {in_reg[6:0], si_s};
      bit_next = bit_reg + 3'h1;
      if (bit_reg == 3'h7) begin
        out_next = rd_byte; // reloaded each byte so busy polls stay live
        if (state_reg == FS_OPCODE) begin
          op_next = op_full;
          state_next = FS_DATA;
        end else begin
          if (cnt_reg == 2'h0) wb1_next = {in_reg[6:0], si_s};
          if (cnt_reg == 2'h1) wb2_next = {in_reg[6:0], si_s};
          if (cnt_reg == 2'h2) wb3_next = {in_reg[6:0], si_s};
          if (cnt_reg != 2'h3) cnt_next = cnt_reg + 2'h1;
        end
      end
    end
    if (sclk_fall && state_reg == FS_DATA) begin
      so_next = out_reg[3'h7 - bit_reg];
    end

    // Execution on frame end; a partial opcode is simply dropped
    if (cs_rise) begin
      state_next = FS_IDLE;
      if (state_reg == FS_DATA) begin
        pfx_next = 2'h0;
        rarm_next = 1'b0;
        unique case (op_reg)
          OP_WREN: if (!busy) wel_next = 1'b1;
          OP_WRDI: if (!busy) wel_next = 1'b0;
          OP_STATUS_WRITE: begin
            // A suspended job must survive, so no status write until it ends
            if (!busy && job_reg == JOB_NONE && status_ok && cnt_reg != 2'h0) begin
              // Only writable fields taken; read-only bits ignored
              bp_next = wb1_reg[B1_PROT_LSB +: 5];
              mlo_next = wb1_reg[B1_METHOD_LO];
              if (cnt_reg >= 2'h2) begin
                mhi_next = wb2_reg[B2_METHOD_HI];
                cmp_next = wb2_reg[B2_CMP];
                lock_next = lock_reg | wb2_reg[B2_LOCK_LSB +: 3];
                otp_next = (pfx_reg == 2'h2) && wb2_reg[B2_METHOD_HI];
              end
              if (cnt_reg == 2'h3) begin
                lat_next = wb3_reg[B3_LAT_LSB +: 2];
                pwr_next = wb3_reg[B3_PWR_ADDR];
              end
              wel_next = 1'b0;
              job_next = JOB_STATUS;
              tmr_next = STATUS_WRITE_CYCLES;
              start_job = 1'b1;
            end
          end
          OP_PAGE_WRITE, OP_SECTOR_WIPE, OP_BLOCK_WIPE, OP_CHIP_WIPE: begin
            // Whole-array check; any protection refuses these commands
            if (!busy && job_reg == JOB_NONE && wel_reg &&
                !any_protected(bp_reg, cmp_reg)) begin
              wel_next = 1'b0;
              job_next = (op_reg == OP_PAGE_WRITE) ? JOB_PROGRAM : JOB_ERASE;
              tmr_next = (op_reg == OP_PAGE_WRITE) ? PROGRAM_CYCLES : ERASE_CYCLES;
              start_job = 1'b1;
            end
          end
          OP_SUSPEND: begin
            if (busy && job_reg == JOB_ERASE) esus_next = 1'b1;
            if (busy && job_reg == JOB_PROGRAM) psus_next = 1'b1;
          end
          OP_RESUME: begin
            esus_next = 1'b0;
            psus_next = 1'b0;
          end
          OP_RESET_ENABLE: rarm_next = 1'b1;
          OP_RESET: soft_rst = rarm_reg;
          OP_ADDR4_ON: cur_next = 1'b1;
          OP_ADDR4_OFF: cur_next = 1'b0;
          OP_PREFIX_A: pfx_next = 2'h1;
          OP_PREFIX_B: pfx_next = (pfx_reg == 2'h1) ? 2'h2 : 2'h0;
          default: ;
        endcase
      end
    end

    // Software reset: abort job, drop latch and suspends, reload width
    if (soft_rst) begin
      job_next = JOB_NONE;
      tmr_next = 16'h0000;
      wel_next = 1'b0;
      esus_next = 1'b0;
      psus_next = 1'b0;
      mhi_next = 1'b0;
      cur_next = pwr_reg;
    end
  end

  // ------------------------------------------------------------------
  // Registers; hardware reset stands for power cycle too
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state_reg <= FS_IDLE;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      op_reg <= 8'h00;
      in_reg <= 8'h00;
      out_reg <= 8'h00;
      wb1_reg <= 8'h00;
      wb2_reg <= 8'h00;
      wb3_reg <= 8'h00;
      bit_reg <= 3'h0;
      cnt_reg <= 2'h0;
      so_reg <= 1'b0;
      job_reg <= JOB_NONE;
      tmr_reg <= 16'h0000;
      wel_reg <= 1'b0;
      bp_reg <= RST_PROTECT;
      mlo_reg <= RST_METHOD[0];
      mhi_reg <= RST_METHOD[1];
      cmp_reg <= RST_CMP;
      lock_reg <= RST_LOCK;
      lat_reg <= RST_LAT;
      pwr_reg <= RST_PWR_ADDR;
      cur_reg <= RST_PWR_ADDR;
      esus_reg <= 1'b0;
      psus_reg <= 1'b0;
      otp_reg <= 1'b0;
      pfx_reg <= 2'h0;
      rarm_reg <= 1'b0;
      fdum_reg <= DUMMY_FAST;
      ddum_reg <= DUMMY_DIO_SHORT;
      qdum_reg <= DUMMY_QIO_SHORT;
    end else if (ce_i) begin
      state_reg <= state_next;
      sclk_prev_reg <= sclk_s;
      cs_prev_reg <= cs_n_s;
      op_reg <= op_next;
      in_reg <= in_next;
      out_reg <= out_next;
      wb1_reg <= wb1_next;
      wb2_reg <= wb2_next;
      wb3_reg <= wb3_next;
      bit_reg <= bit_next;
      cnt_reg <= cnt_next;
      so_reg <= so_next;
      job_reg <= job_next;
      tmr_reg <= tmr_next;
      wel_reg <= wel_next;
      bp_reg <= bp_next;
      mlo_reg <= mlo_next;
      mhi_reg <= mhi_next;
      cmp_reg <= cmp_next;
      lock_reg <= lock_next;
      lat_reg <= lat_next;
      pwr_reg <= pwr_next;
      cur_reg <= cur_next;
      esus_reg <= esus_next;
      psus_reg <= psus_next;
      otp_reg <= otp_next;
      pfx_reg <= pfx_next;
      rarm_reg <= rarm_next;
      fdum_reg <= DUMMY_FAST;
      ddum_reg <= dio_dummy(lat_reg);
      qdum_reg <= qio_dummy(lat_reg);
    end
  end

  // Outputs
  assign so_o = so_reg;
  assign so_oe_n_o = !(state_reg == FS_DATA && reading && !cs_n_s);
  assign fast_dummy_o = fdum_reg;
  assign dual_io_dummy_o = ddum_reg;
  assign quad_io_dummy_o = qdum_reg;
  assign current_addr_width_o = cur_reg;
  assign security_lock_o = lock_reg;
  assign quad_io_enable_o = sb2[B2_QE];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  AST_BUSY_AFTER_START: assert property (ce_i && start_job |=> sb1[B1_BUSY])
    else $error("busy not shown after a job start");
  AST_WEL_GATES: assert property (ce_i && cs_rise && state_reg == FS_DATA && !wel_reg
      |-> !start_job ##1 $stable(bp_reg))
    else $error("write accepted with latch clear");
  AST_HW_LOCK: assert property (ce_i && cs_rise && mlo_reg && !mhi_reg && !wp_n_s
      |=> $stable({bp_reg, cmp_reg, lat_reg}))
    else $error("status changed while hardware protected");
  AST_CHIP_ERASE_PROT: assert property (ce_i && cs_rise && state_reg == FS_DATA &&
      op_reg == OP_CHIP_WIPE && job_reg == JOB_NONE && any_protected(bp_reg, cmp_reg)
      |=> job_reg == JOB_NONE)
    else $error("chip erase started with protection active");
  AST_QE_ONE: assert property (sb2[B2_QE] && quad_io_enable_o)
    else $error("quad enable not one");
  AST_LOCK_STICKY: assert property ((lock_reg & $past(lock_reg)) == $past(lock_reg))
    else $error("security lock bit cleared");
  AST_RESUME_CLEARS: assert property (ce_i && cs_rise && state_reg == FS_DATA &&
      op_reg == OP_RESUME |=> !esus_reg && !psus_reg)
    else $error("suspend bits survive resume");
  AST_OTP_FROZEN: assert property (otp_reg |=> otp_reg && $stable(bp_reg))
    else $error("status changed after permanent lock");
  AST_QIO_LONG: assert property (ce_i && lat_reg == 2'b11 |=>
      quad_io_dummy_o == DUMMY_QIO_LONG)
    else $error("quad io dummy count wrong");
  AST_SOFT_RESET_ADDR: assert property (ce_i && soft_rst |=>
      cur_reg == pwr_reg && !mhi_reg)
    else $error("soft reset did not reload address width");

  COV_STATUS_WRITE: cover property (start_job && op_reg == OP_STATUS_WRITE);
  COV_ERASE_SUSPEND: cover property (esus_reg && job_reg == JOB_ERASE);
  COV_READ_BUSY: cover property (!so_oe_n_o && busy);

endmodule : fsrb_top

`default_nettype wire

/* verilog/fsrb_pkg.sv */
// Constants for the flash status register bank: opcodes, bit positions,
// reset values, dummy-cycle counts and the command state type.
// Assumes a single-line serial command interface sampled by clk_i.
`default_nettype none

package fsrb_pkg;

  // ------------------------------------------------------------------
  // Command opcodes
  // ------------------------------------------------------------------
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ_SB1 = 8'h05;
  localparam logic [7:0] OP_READ_SB2 = 8'h35;
  localparam logic [7:0] OP_READ_SB3 = 8'h15;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hd8;
  localparam logic [7:0] OP_CHIP_WIPE = 8'hc7;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_RESUME = 8'h7a;
  localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
  localparam logic [7:0] OP_RESET = 8'h99;
  localparam logic [7:0] OP_ADDR4_ON = 8'hb7;
  localparam logic [7:0] OP_ADDR4_OFF = 8'he9;
  localparam logic [7:0] OP_PREFIX_A = 8'haa;
  localparam logic [7:0] OP_PREFIX_B = 8'h55;

  // ------------------------------------------------------------------
  // Bit positions inside each status byte
  // ------------------------------------------------------------------
  localparam int B1_BUSY = 0;
  localparam int B1_WEL = 1;
  localparam int B1_PROT_LSB = 2;
  localparam int B1_METHOD_LO = 7;
  localparam int B2_METHOD_HI = 0;
  localparam int B2_QE = 1;
  localparam int B2_PSUS = 2;
  localparam int B2_LOCK_LSB = 3;
  localparam int B2_CMP = 6;
  localparam int B2_ESUS = 7;
  localparam int B3_LAT_LSB = 0;
  localparam int B3_CUR_ADDR = 3;
  localparam int B3_PWR_ADDR = 4;

  // ------------------------------------------------------------------
  // Reset values of the stored fields
  // ------------------------------------------------------------------
  localparam logic [4:0] RST_PROTECT = 5'h00;
  localparam logic [1:0] RST_METHOD = 2'h0;
  localparam logic RST_CMP = 1'b0;
  localparam logic [2:0] RST_LOCK = 3'h0;
  localparam logic [1:0] RST_LAT = 2'h0;
  localparam logic RST_PWR_ADDR = 1'b0;
  localparam logic [3:0] RST_PINS = 4'ha; // wp_n=1, si=0, cs_n=1, sclk=0

  // ------------------------------------------------------------------
  // Dummy clock counts
  // ------------------------------------------------------------------
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_DIO_SHORT = 4'h4;
  localparam logic [3:0] DUMMY_DIO_LONG = 4'h8;
  localparam logic [3:0] DUMMY_QIO_SHORT = 4'h6;
  localparam logic [3:0] DUMMY_QIO_MID = 4'h8;
  localparam logic [3:0] DUMMY_QIO_LONG = 4'ha;

  // ------------------------------------------------------------------
  // Busy durations in clk_i cycles
  // ------------------------------------------------------------------
  localparam logic [15:0] STATUS_WRITE_CYCLES = 16'h0040;
  localparam logic [15:0] PROGRAM_CYCLES = 16'h0100;
  localparam logic [15:0] ERASE_CYCLES = 16'h0400;

  // Background job kinds
  localparam logic [1:0] JOB_NONE = 2'h0;
  localparam logic [1:0] JOB_STATUS = 2'h1;
  localparam logic [1:0] JOB_PROGRAM = 2'h2;
  localparam logic [1:0] JOB_ERASE = 2'h3;

  // Command frame states, Gray along idle-opcode-data
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_OPCODE = 2'b01,
    FS_DATA = 2'b11
  } fsrb_state_t;

endpackage : fsrb_pkg

`default_nettype wire

/* verilog/fsrb_pin_sync.sv */
// Three-flop input synchroniser with agreement filter.
// Assumes inputs are asynchronous to clk_i; output moves only when the
// second and third stages agree.
`default_nettype none

module fsrb_pin_sync #(
  parameter int W = 4,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and control
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // Pins in, filtered levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] stable_o
);

  logic [W-1:0] s1_reg, s2_reg, s3_reg, st_reg;
  logic [W-1:0] s1_next, s2_next, s3_next, st_next;

  // Next values; first stage feeds only the second
  always_comb begin
    s1_next = async_i;
    s2_next = s1_reg;
    s3_next = s2_reg;
    st_next = st_reg;
    for (int i = 0; i < W; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        st_next[i] = s3_reg[i];
      end
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s1_reg <= RST;
      s2_reg <= RST;
      s3_reg <= RST;
      st_reg <= RST;
    end else if (ce_i) begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      st_reg <= st_next;
    end
  end

  assign stable_o = st_reg;

endmodule : fsrb_pin_sync

`default_nettype wire

/* sim/fsrb_host_model.sv */
// Host controller model: shifts command frames out, reads one byte back.
// Assumes the device samples the pins with its own faster clock.
`default_nettype none

module fsrb_host_model (
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic si_o,
  input wire logic so_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle: clock low and still, device deselected
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o = 1'b0;
  end

  // Frame of n bytes MSB first, then a byte in when rd is set
  task automatic frame(input logic [31:0] d, input int n, input bit rd,
                       output logic [7:0] q);
    q = 8'h00;
    cs_n_o = 1'b0;
    #32;
    for (int i = 8 * n - 1; i >= 0; i--) begin
      si_o = d[i];
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    for (int i = 7; i >= 0 && rd; i--) begin
      #32 sclk_o = 1'b1;
      q[i] = so_i;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    si_o = ~si_o; // No stale data on a released line
    #100;
  endtask : frame

endmodule : fsrb_host_model

`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the status register bank.
// Assumes the host model drives the serial pins; ce_i held high.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import fsrb_pkg::*;

  logic clk_i, resetn_i, wp_n_i, sclk, cs_n, si, so, awid, qe, oen, oel;
  logic [3:0] fd, dd, qd;
  logic [2:0] lock;
  logic [7:0] q, lk, r;
  int n_mismatch = 0, checks_done = 0, cyc = 0, seed;

  fsrb_top fsrb_top_inst (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1),
    .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
    .so_oe_n_o(oen), .fast_dummy_o(fd), .dual_io_dummy_o(dd),
    .quad_io_dummy_o(qd), .current_addr_width_o(awid),
    .security_lock_o(lock), .quad_io_enable_o(qe));
  fsrb_host_model fsrb_host_model_inst (.sclk_o(sclk), .cs_n_o(cs_n),
    .si_o(si), .so_i(so));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard, far above the longest sequence
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic op(input logic [7:0] o);
    fsrb_host_model_inst.frame({24'h0, o}, 1, 1'b0, q);
  endtask : op

  // Read frame; output enable sampled well inside the data phase
  task automatic rd(input logic [7:0] o);
    fork
      fsrb_host_model_inst.frame({24'h0, o}, 1, 1'b1, q);
      #700 oel = oen;
    join
  endtask : rd

  // Enable, then write n bytes {b1,b2,b3}; wait out the busy time
  task automatic wsr(input logic [23:0] b, input int n);
    op(OP_WREN);
    fsrb_host_model_inst.frame({OP_STATUS_WRITE, b} >> (8 * (3 - n)), n + 1, 1'b0, q);
    repeat (80) @(posedge clk_i);
  endtask : wsr

  function automatic logic [7:0] dio(input logic [1:0] s);
    return s[0] ? 8'h08 : 8'h04;
  endfunction : dio

  function automatic logic [7:0] qio(input logic [1:0] s);
    return (s == 2'h3) ? 8'h0a : (s == 2'h2) ? 8'h08 : 8'h06;
  endfunction : qio

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'he022;
    resetn_i = 1'b0;
    wp_n_i = 1'b1;
    lk = 8'h00;
    repeat (6) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rd(OP_READ_SB2);
    chk("sb2", q, 8'h02);
    chk("qe", {7'h0, qe}, 8'h01);
    fsrb_host_model_inst.frame({16'h0, OP_STATUS_WRITE, 8'h7c}, 2, 1'b0, q);
    rd(OP_READ_SB1);
    chk("nowel", q, 8'h00);
    chk("oel", {7'h0, oel}, 8'h00);
    chk("oen", {7'h0, oen}, 8'h01);
    op(OP_WREN);
    rd(OP_READ_SB1);
    chk("wel", q, 8'h02);
    op(OP_WRDI);
    rd(OP_READ_SB1);
    chk("wrdi", q, 8'h00);
    // All latency codes; read-only bits written as ones except quad enable, reserved as zero
    for (int k = 0; k < 4; k++) begin
      r = $random(seed) & 8'h38;
      lk = lk | r;
      wsr({8'h03, r | 8'h84, 3'h0, k[0], 2'h2, k[1:0]}, 3);
      rd(OP_READ_SB1);
      chk("sb1", q, 8'h00);
      rd(OP_READ_SB2);
      chk("sb2", q, lk | 8'h02);
      rd(OP_READ_SB3);
      chk("sb3", q, {3'h0, k[0], 2'h0, k[1:0]});
      chk("fast", {4'h0, fd}, 8'h08);
      chk("dio", {4'h0, dd}, dio(k[1:0]));
      chk("qio", {4'h0, qd}, qio(k[1:0]));
      chk("lock", {5'h0, lock}, {5'h0, lk[5:3]});
    end
    op(OP_RESET_ENABLE);
    op(OP_RESET);
    chk("adr", {7'h0, awid}, 8'h01);
    op(OP_ADDR4_OFF);
    chk("adr", {7'h0, awid}, 8'h00);
    op(OP_ADDR4_ON);
    rd(OP_READ_SB3);
    chk("sb3a", q, 8'h1b);
    // Protected area refuses chip erase and sector erase
    wsr({8'h04, 16'h0}, 1);
    op(OP_WREN);
    op(OP_CHIP_WIPE);
    rd(OP_READ_SB1);
    chk("ce", {7'h0, q[0]}, 8'h00);
    // Refused commands leave the latch set
    op(OP_SECTOR_WIPE);
    rd(OP_READ_SB1);
    chk("prot", q, 8'h06);
    // Complement with bp 01100 protects nothing: erase runs, then suspends
    wsr({8'h30, lk | 8'h40, 8'h0}, 2);
    op(OP_WREN);
    op(OP_CHIP_WIPE);
    rd(OP_READ_SB1);
    chk("busy", {7'h0, q[0]}, 8'h01);
    op(OP_SUSPEND);
    rd(OP_READ_SB2);
    chk("esus", q, lk | 8'hc2);
    op(OP_RESUME);
    rd(OP_READ_SB2);
    chk("res", q, lk | 8'h42);
    repeat (1100) @(posedge clk_i);
    wsr({8'h00, lk, 8'h0}, 2);
    op(OP_WREN);
    fsrb_host_model_inst.frame({OP_PAGE_WRITE, 24'h0}, 4, 1'b0, q);
    op(OP_SUSPEND);
    rd(OP_READ_SB2);
    chk("psus", q, lk | 8'h06);
    op(OP_RESET_ENABLE);
    op(OP_RESET);
    rd(OP_READ_SB2);
    chk("srst", q, lk | 8'h02);
    // Protection methods
    wsr({8'h80, 16'h0}, 1);
    @(negedge clk_i);
    wp_n_i = 1'b0;
    wsr({8'h84, 16'h0}, 1);
    rd(OP_READ_SB1);
    chk("hwp", q, 8'h82);
    @(negedge clk_i);
    wp_n_i = 1'b1;
    wsr({8'h84, 16'h0}, 1);
    rd(OP_READ_SB1);
    chk("hwu", q, 8'h84);
    wsr({8'h00, lk | 8'h01, 8'h0}, 2);
    wsr({8'h08, 16'h0}, 1);
    rd(OP_READ_SB1);
    chk("pld", q, 8'h02);
    op(OP_RESET_ENABLE);
    op(OP_RESET);
    wsr({8'h08, 16'h0}, 1);
    rd(OP_READ_SB1);
    chk("unl", q, 8'h08);
    // Latch first: any frame between the prefix pair and the write disarms it
    op(OP_WREN);
    op(OP_PREFIX_A);
    op(OP_PREFIX_B);
    fsrb_host_model_inst.frame({8'h0, OP_STATUS_WRITE, 8'h00, lk | 8'h01}, 3, 1'b0, q);
    repeat (80) @(posedge clk_i);
    op(OP_RESET_ENABLE);
    op(OP_RESET);
    wsr({8'h0c, 16'h0}, 1);
    rd(OP_READ_SB1);
    chk("otp", q, 8'h02);
    tally_and_finish();
  end

endmodule : tb_top

`default_nettype wire
